// ---- src/arb_pkg.sv ----
// Purpose: shared constants and types for the command source arbiter
// Assumes: pclk at 200 MHz, APB register access with 32-bit data
// Notes: register offsets are byte addresses on the APB bus
package arb_pkg;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int DEBOUNCE_TIME_NS = 10000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS * CLK_FREQ_MHZ + 999)
    / 1000;
  localparam int DEBOUNCE_CNT_W = 12;

  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_BUS_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SAFETY = 8'h0C;

  // config register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_PARALLEL = 2;
  localparam int CFG_EMERG_EN = 3;
  localparam int CFG_LOSS_FIRST = 4;
  localparam int CFG_RELAY_EN = 5;
  localparam int CFG_LAMP_EN = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // fieldbus cyclic output fields
  localparam int CMD_OPEN = 0;
  localparam int CMD_CLOSE = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_POSITION = 3;
  localparam int CMD_RESET = 4;
  localparam int CMD_SETPOINT_LSB = 8;
  localparam logic [15:0] BUS_CMD_RESET = 16'h0000;

  // status word: low byte is status byte 13, next byte not-ready byte 9
  localparam int STAT_EMSTOP = 4;
  localparam int STAT_EMERG_MODE = 5;
  localparam int STAT_EXT_CTRL = 7;
  localparam int STAT_NOT_READY_LSB = 8;
  localparam int STAT_RUN_LSB = 16;

  localparam int SAFE_ACTION_LSB = 8;
  localparam logic [9:0] SAFETY_RESET = 10'h000;

  localparam logic [3:0] DEBOUNCE_RESET = 4'h2;

  typedef enum logic [1:0] {
    MODE_STANDARD,
    MODE_OPEN_CLOSE_MOD,
    MODE_OPEN_CLOSE_STOP,
    MODE_OPEN_CLOSE_ESD
  } input_mode_type;

  typedef enum logic [1:0] {
    ACT_STOP,
    ACT_OPEN,
    ACT_CLOSE,
    ACT_SAFETY_POS
  } emerg_action_type;
endpackage

// ---- src/debounce_filter.sv ----
// Purpose: two-stage synchroniser plus stability filter per input bit
// Assumes: inputs may be asynchronous and bouncing
// Notes: output follows only after DEBOUNCE_CYCLES of a steady level
module debounce_filter import arb_pkg::*; #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] clean_out
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic stable;
    logic [DEBOUNCE_CNT_W-1:0] cnt;
  } bit_state_type;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    bit_state_type s_reg;
    bit_state_type s_next;

    always_comb begin
      s_next = s_reg;
      s_next.sync1 = raw_in[i];
      s_next.sync2 = s_reg.sync1;
      if (s_reg.sync2 == s_reg.stable) begin
        s_next.cnt = '0;
      end else if (s_reg.cnt == DEBOUNCE_CNT_W'(DEBOUNCE_CYCLES - 1)) begin
        s_next.stable = s_reg.sync2;
        s_next.cnt = '0;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s_reg <= '{RESET_VALUE[i], RESET_VALUE[i], RESET_VALUE[i], '0};
      end else begin
        s_reg <= s_next;
      end
    end

    assign clean_out[i] = s_reg.stable;
  end
endmodule

// ---- src/self_retain_latch.sv ----
// Purpose: self-retaining open/close memory for wired commands
// Assumes: request inputs already synchronous to pclk
// Notes: stop, clear or loss of enable drops the held command
module self_retain_latch import arb_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic clear,
  input wire logic open_req,
  input wire logic close_req,
  input wire logic stop_req,
  output logic open_held,
  output logic close_held
);
  typedef struct packed {
    logic open;
    logic close;
  } latch_state_type;

  latch_state_type s_reg;
  latch_state_type s_next;

  always_comb begin
    s_next = s_reg;
    if (!enable || clear || stop_req || (open_req && close_req)) begin
      s_next = '0;
    end else if (open_req) begin
      s_next.open = 1'b1;
      s_next.close = 1'b0;
    end else if (close_req) begin
      s_next.open = 1'b0;
      s_next.close = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign open_held = s_reg.open;
  assign close_held = s_reg.close;
endmodule

// ---- src/command_source_arbiter.sv ----
// Purpose: choose the source of actuator commands and report status
// Assumes: APB master, wired inputs and selector synchronous or filtered
// Notes: priority is emergency-stop, emergency, selector, source-select
//
// Overview of operation
// - open/close/stop mode ignores both analogue inputs
// - source-select idle: only fieldbus commands act
// - source-select in stop mode: wired, self-retained
// - remote commands only with selector in remote
// - external-control bit set while wired inputs rule
// - emergency-mode bit set while emergency demanded
// - parallel fitted: wired open/close or setpoint
// - feedback outputs stay driven under bus priority
// - mode low: first analogue input is setpoint
// - setpoint loss drives to safety position
// - low emergency input wins over everything but emergency-stop
// - emergency blocks wired and fieldbus movement
// - after emergency, wired commands must be reapplied
// - no automatic change-over on bus loss
// - emergency-stop cuts contactors, clears commands
// - emergency-stop flag in not-ready byte bit four
// - optional relay and lamp follow emergency-stop button
// - command held off until stop state confirmed
// - local reset accepted only with selector local
// - fieldbus reset bit confirms with selector remote
// - clear needs release first, then reset
//
// Implementation choices: the placing of the registers and the APB slave port.
module command_source_arbiter import arb_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic source_select,
  input wire logic emergency_input_n,
  input wire logic emstop_button,
  input wire logic local_reset_button,
  input wire logic selector_remote,
  input wire logic selector_local,
  input wire logic mode_input,
  input wire logic wired_open,
  input wire logic wired_close,
  input wire logic wired_stop,
  input wire logic [7:0] analogue_input_first,
  input wire logic [7:0] analogue_input_second,
  input wire logic setpoint_lost,
  input wire logic [7:0] actuator_position,
  output logic run_open,
  output logic run_close,
  output logic position_mode,
  output logic [7:0] position_setpoint,
  output logic contactor_supply_en,
  output logic emstop_relay,
  output logic emstop_lamp,
  output logic [7:0] position_feedback
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [15:0] bus_cmd;
    logic [9:0] safety;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic emstop_latched;
    logic released_seen;
    logic bus_reset_prev;
    logic local_reset_prev;
    logic emerg_prev;
    logic wired_block;
    logic run_open;
    logic run_close;
    logic pos_mode;
    logic [7:0] pos_setpoint;
    logic contactor_en;
    logic relay;
    logic lamp;
    logic [7:0] feedback;
    logic ext_ctrl;
    logic emerg_mode;
  } arb_state_type;

  arb_state_type s_reg;
  arb_state_type s_next;

  logic [3:0] raw_vec;
  logic [3:0] clean_vec;
  logic sel_db;
  logic emerg_n_db;
  logic emstop_db;
  logic reset_db;
  logic wired_open_held;
  logic wired_close_held;
  logic retain_enable;
  logic retain_clear;

  input_mode_type in_mode;
  emerg_action_type emerg_act;
  logic [7:0] not_ready;
  logic [7:0] status_byte;
  logic [31:0] status_word;
  logic emerg_demand;
  logic wired_rules;
  logic reset_event;
  logic bus_write;
  logic [7:0] analogue_unused;
  logic apb_setup;
  logic stop_state;
  logic bus_open;
  logic bus_close;
  logic direct_open;
  logic direct_close;

  assign raw_vec = {local_reset_button, emstop_button, emergency_input_n,
    source_select};

  // bit 1 (emergency, active low) resets high so power-up is not a demand
  debounce_filter #(
    .WIDTH(4),
    .RESET_VALUE(DEBOUNCE_RESET)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(raw_vec),
    .clean_out(clean_vec)
  );

  assign sel_db = clean_vec[0];
  assign emerg_n_db = clean_vec[1];
  assign emstop_db = clean_vec[2];
  assign reset_db = clean_vec[3];

  assign in_mode = input_mode_type'(s_reg.cfg[CFG_MODE_LSB +: 2]);
  assign emerg_act = emerg_action_type'(s_reg.safety[SAFE_ACTION_LSB +: 2]);
  // second analogue input has no command role in any mode handled here
  assign analogue_unused = analogue_input_second;

  // wired inputs only take over in a command mode with source-select high
  assign wired_rules = sel_db && selector_remote
    && (s_reg.cfg[CFG_PARALLEL] || in_mode != MODE_STANDARD);

  assign emerg_demand = s_reg.cfg[CFG_EMERG_EN] && !emerg_n_db
    && (s_reg.cfg[CFG_PARALLEL] || in_mode == MODE_OPEN_CLOSE_ESD);

  // self-retention exists only in open/close/stop mode under wired control
  assign retain_enable = wired_rules && !s_reg.cfg[CFG_PARALLEL]
    && in_mode == MODE_OPEN_CLOSE_STOP && !emerg_demand;
  // the latch outlives the button, so both keep commands off
  assign stop_state = emstop_db || s_reg.emstop_latched;
  assign retain_clear = stop_state;

  self_retain_latch u_retain (
    .pclk(pclk),
    .presetn(presetn),
    .enable(retain_enable),
    .clear(retain_clear),
    .open_req(wired_open),
    .close_req(wired_close),
    .stop_req(wired_stop),
    .open_held(wired_open_held),
    .close_held(wired_close_held)
  );

  // rising edges only, so a held button or bit cannot confirm early
  assign reset_event = (reset_db && !s_reg.local_reset_prev
    && selector_local)
    || (s_reg.bus_cmd[CMD_RESET] && !s_reg.bus_reset_prev
    && selector_remote);

  always_comb begin
    not_ready = '0;
    not_ready[STAT_EMSTOP] = s_reg.emstop_latched;
    status_byte = '0;
    status_byte[STAT_EXT_CTRL] = s_reg.ext_ctrl;
    status_byte[STAT_EMERG_MODE] = s_reg.emerg_mode;
    status_word = '0;
    status_word[7:0] = status_byte;
    status_word[STAT_NOT_READY_LSB +: 8] = not_ready;
    // run and contactor bits show the master what was finally decided
    status_word[STAT_RUN_LSB] = s_reg.run_open;
    status_word[STAT_RUN_LSB + 1] = s_reg.run_close;
    status_word[STAT_RUN_LSB + 2] = s_reg.pos_mode;
    status_word[STAT_RUN_LSB + 3] = s_reg.contactor_en;
  end

  assign bus_write = psel && penable && pwrite && s_reg.pready;
  assign apb_setup = psel && !penable;

  // a word asking for both directions, or for stop, gives no open or close run
  assign bus_open = s_reg.bus_cmd[CMD_OPEN] && !s_reg.bus_cmd[CMD_CLOSE]
    && !s_reg.bus_cmd[CMD_STOP];
  assign bus_close = s_reg.bus_cmd[CMD_CLOSE] && !s_reg.bus_cmd[CMD_OPEN]
    && !s_reg.bus_cmd[CMD_STOP];

  // unlatched wired levels; both high together count as no command
  assign direct_open = wired_open && !wired_close && !s_reg.wired_block;
  assign direct_close = wired_close && !wired_open && !s_reg.wired_block;

  always_comb begin
    s_next = s_reg;

    // apb: answer decided in setup, ready in the first access cycle
    s_next.pready = apb_setup;
    // the error flag lives only beside its pready, never into later cycles
    s_next.pslverr = 1'b0;
    if (apb_setup) begin
      // status comes from registered state, never a half-updated word
      s_next.prdata = '0;
      case (paddr)
        ADDR_CONFIG: s_next.prdata[7:0] = s_reg.cfg;
        ADDR_BUS_CMD: s_next.prdata[15:0] = s_reg.bus_cmd;
        ADDR_STATUS: s_next.prdata = status_word;
        ADDR_SAFETY: s_next.prdata[9:0] = s_reg.safety;
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (bus_write) begin
      case (paddr)
        ADDR_CONFIG: s_next.cfg = pwdata[7:0];
        ADDR_BUS_CMD: s_next.bus_cmd = pwdata[15:0];
        ADDR_SAFETY: s_next.safety = pwdata[9:0];
        // status is read-only; a write there is dropped without an error
        default: s_next.cfg = s_reg.cfg;
      endcase
    end

    // last cycle's levels for the rising-edge detectors and the wired block
    s_next.bus_reset_prev = s_reg.bus_cmd[CMD_RESET];
    s_next.local_reset_prev = reset_db;
    s_next.emerg_prev = emerg_demand;

    // emergency-stop latch; engaging again beats a same-cycle clear
    if (s_reg.emstop_latched && !emstop_db) begin
      s_next.released_seen = 1'b1;
    end
    if (s_reg.released_seen && reset_event) begin
      s_next.emstop_latched = 1'b0;
      s_next.released_seen = 1'b0;
    end
    if (emstop_db) begin
      s_next.emstop_latched = 1'b1;
      s_next.released_seen = 1'b0;
    end

    // wired open/close stay blocked through the emergency and the edge
    // after it, so levels still present then must drop and come again
    if (emerg_demand || s_reg.emerg_prev) begin
      s_next.wired_block = 1'b1;
    end else if (!wired_open && !wired_close) begin
      s_next.wired_block = 1'b0;
    end

    s_next.contactor_en = !emstop_db;
    s_next.relay = emstop_db && s_reg.cfg[CFG_RELAY_EN];
    s_next.lamp = emstop_db && s_reg.cfg[CFG_LAMP_EN];
    s_next.ext_ctrl = wired_rules;
    s_next.emerg_mode = emerg_demand;
    // feedback follows the actuator whichever source has priority
    s_next.feedback = actuator_position;

    // runs fall back to still; each branch below asks for one at most
    s_next.run_open = 1'b0;
    s_next.run_close = 1'b0;
    s_next.pos_mode = 1'b0;
    s_next.pos_setpoint = s_reg.pos_setpoint;

    if (stop_state) begin
      // nothing moves until the stop state is confirmed
      s_next.pos_setpoint = s_reg.pos_setpoint;
    end else if (emerg_demand) begin
      // emergency ignores selector, source-select and fieldbus
      case (emerg_act)
        ACT_OPEN: s_next.run_open = 1'b1;
        ACT_CLOSE: s_next.run_close = 1'b1;
        ACT_SAFETY_POS: begin
          s_next.pos_mode = 1'b1;
          s_next.pos_setpoint = s_reg.safety[7:0];
        end
        // stop action: both runs stay low from the defaults above
        default: s_next.run_open = 1'b0;
      endcase
    end else if (!selector_remote) begin
      // local or off: no remote source may command movement
      s_next.pos_mode = 1'b0;
    end else if (wired_rules) begin
      if (s_reg.cfg[CFG_PARALLEL] || in_mode == MODE_OPEN_CLOSE_MOD) begin
        if (mode_input) begin
          s_next.run_open = direct_open;
          s_next.run_close = direct_close;
        end else if (setpoint_lost && s_reg.cfg[CFG_LOSS_FIRST]) begin
          s_next.pos_mode = 1'b1;
          s_next.pos_setpoint = s_reg.safety[7:0];
        end else begin
          s_next.pos_mode = 1'b1;
          s_next.pos_setpoint = analogue_input_first;
        end
      end else if (in_mode == MODE_OPEN_CLOSE_STOP) begin
        s_next.run_open = wired_open_held && !s_reg.wired_block;
        s_next.run_close = wired_close_held && !s_reg.wired_block;
      end else begin
        s_next.run_open = direct_open;
        s_next.run_close = direct_close;
      end
    end else begin
      // bus keeps priority even when its link has gone quiet
      if (s_reg.bus_cmd[CMD_POSITION]) begin
        s_next.pos_mode = 1'b1;
        s_next.pos_setpoint = s_reg.bus_cmd[CMD_SETPOINT_LSB +: 8];
      end else begin
        s_next.run_open = bus_open;
        s_next.run_close = bus_close;
      end
    end
  end

  // reset leaves every output low, contactor supply included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
      s_reg.bus_cmd <= BUS_CMD_RESET;
      s_reg.safety <= SAFETY_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign run_open = s_reg.run_open;
  assign run_close = s_reg.run_close;
  assign position_mode = s_reg.pos_mode;
  assign position_setpoint = s_reg.pos_setpoint;
  assign contactor_supply_en = s_reg.contactor_en;
  assign emstop_relay = s_reg.relay;
  assign emstop_lamp = s_reg.lamp;
  assign position_feedback = s_reg.feedback;
endmodule

// ---- tb/field_panel.sv ----
// Purpose: wired field side of the arbiter: panel, selector box, e-stop
// Assumes: bench sets the wanted levels just after a clock edge
// Notes: a disconnected cable reads as low on every wired line except the e-stop button
module field_panel (
  input wire logic connected,
  input wire logic want_wired,
  input wire logic emerg_clear,
  input wire logic estop_pressed,
  input wire logic open_lvl,
  input wire logic close_lvl,
  input wire logic stop_lvl,
  output logic source_select,
  output logic emergency_input_n,
  output logic emstop_button,
  output logic wired_open,
  output logic wired_close,
  output logic wired_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  // an open wire never selects the wired source
  assign source_select = connected & want_wired;
  // an open wire is an emergency demand
  assign emergency_input_n = connected & emerg_clear;
  assign emstop_button = estop_pressed;
  // commands are dropped and raised again by the panel
  assign wired_open = connected & open_lvl;
  assign wired_close = connected & close_lvl;
  assign wired_stop = connected & stop_lvl;
endmodule

// ---- tb/arb_chk.sv ----
// Purpose: port-level checks for the command source arbiter
// Assumes: APB slave answers in the first access cycle
// Notes: bound onto every instance of the arbiter
module arb_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] actuator_position,
  input wire logic run_open,
  input wire logic run_close,
  input wire logic contactor_supply_en,
  input wire logic emstop_relay,
  input wire logic emstop_lamp,
  input wire logic [7:0] position_feedback
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready_next;
    psel && !penable |=> pready && psel && penable;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("pready not in first access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error answer without pready or with data");
  property p_feedback;
    $past(presetn) |-> position_feedback == $past(actuator_position);
  endproperty
  a_feedback: assert property (p_feedback)
    else $error("position feedback not one cycle behind");
  property p_one_dir;
    !(run_open && run_close);
  endproperty
  a_one_dir: assert property (p_one_dir)
    else $error("open and close driven together");
  property p_cut_runs;
    !contactor_supply_en && $past(!contactor_supply_en)
      |-> !run_open && !run_close;
  endproperty
  a_cut_runs: assert property (p_cut_runs)
    else $error("movement while contactor supply cut");
  property p_relay_cut;
    emstop_relay |-> !contactor_supply_en;
  endproperty
  a_relay_cut: assert property (p_relay_cut)
    else $error("relay on with contactor supply on");
  property p_lamp_cut;
    emstop_lamp |-> !contactor_supply_en;
  endproperty
  a_lamp_cut: assert property (p_lamp_cut)
    else $error("lamp on with contactor supply on");
  property p_cut_hold;
    $fell(contactor_supply_en) |=> !contactor_supply_en [*8];
  endproperty
  a_cut_hold: assert property (p_cut_hold)
    else $error("contactor supply glitched");
  c_relay: cover property (emstop_relay);
  c_err: cover property (pslverr);
  c_close: cover property (run_close);
endmodule

bind command_source_arbiter arb_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .actuator_position(actuator_position),
  .run_open(run_open),
  .run_close(run_close),
  .contactor_supply_en(contactor_supply_en),
  .emstop_relay(emstop_relay),
  .emstop_lamp(emstop_lamp),
  .position_feedback(position_feedback)
);

// ---- tb/command_source_arbiter_tb.sv ----
// Purpose: self-checking bench for the command source arbiter
// Assumes: filters follow a changed input within DEBOUNCE_CYCLES + 2
// Notes: status is read back over APB and checked from a note queue
module command_source_arbiter_tb import arb_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE = DEBOUNCE_CYCLES + 6;
  localparam logic [31:0] M = 32'h000F10A0;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_type;
  note_type notes[$];
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, position_setpoint, position_feedback;
  logic [31:0] pwdata, prdata, seed;
  logic source_select, emergency_input_n, emstop_button;
  logic local_reset_button, selector_remote, selector_local, mode_input;
  logic wired_open, wired_close, wired_stop, setpoint_lost;
  logic [7:0] analogue_input_first, analogue_input_second;
  logic [7:0] actuator_position;
  logic run_open, run_close, position_mode, contactor_supply_en;
  logic emstop_relay, emstop_lamp, rnd_on;
  logic connected, want_wired, emerg_clear, estop_pressed;
  logic open_lvl, close_lvl, stop_lvl;
  int err_total, tests_run;

  command_source_arbiter dut (.*);
  field_panel u_field (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [32:0] seen,
                       input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one APB transfer; the expected answer goes to the note queue first
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    notes.push_back('{d, m, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count is assumed; only the watchdog ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic st(input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, ADDR_STATUS, e, m, 1'b0);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      note_type t;
      t = notes.pop_front();
      check("apb", {pslverr, prdata & t.m}, {t.e, t.d & t.m});
    end
  end

  always @(posedge pclk) begin
    if (rnd_on) begin
      seed <= lfsr(seed);
      analogue_input_first <= seed[7:0];
      analogue_input_second <= seed[15:8];
      actuator_position <= seed[23:16];
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {local_reset_button, selector_local, mode_input, close_lvl} = '0;
    {setpoint_lost, want_wired, estop_pressed, open_lvl, stop_lvl} = '0;
    {analogue_input_first, analogue_input_second} = '0;
    actuator_position = 8'h00;
    {selector_remote, connected, emerg_clear, rnd_on} = 4'hF;
    seed = 32'h08FFBA4A;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    apb(1'b0, ADDR_CONFIG, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 8'h10, 32'h0, 32'h0, 1'b1);
    wr(ADDR_BUS_CMD, 32'h1);
    idle(3);
    st(32'h00090000, M);
    selector_remote <= 1'b0;
    idle(3);
    st(32'h00080000, M);
    selector_remote <= 1'b1;
    wr(ADDR_CONFIG, 32'h2);
    wr(ADDR_BUS_CMD, 32'h2);
    want_wired <= 1'b1;
    idle(SETTLE);
    st(32'h00080080, M);
    open_lvl <= 1'b1;
    idle(3);
    open_lvl <= 1'b0;
    idle(3);
    st(32'h00090080, M);
    stop_lvl <= 1'b1;
    idle(3);
    stop_lvl <= 1'b0;
    idle(3);
    st(32'h00080080, M);
    wr(ADDR_BUS_CMD, 32'h1);
    wr(ADDR_CONFIG, 32'h0B);
    wr(ADDR_SAFETY, 32'h200);
    open_lvl <= 1'b1;
    emerg_clear <= 1'b0;
    idle(SETTLE);
    st(32'h000A0020, 32'h000F1020);
    emerg_clear <= 1'b1;
    idle(SETTLE);
    st(32'h00080080, M);
    open_lvl <= 1'b0;
    idle(3);
    open_lvl <= 1'b1;
    idle(3);
    st(32'h00090080, M);
    open_lvl <= 1'b0;
    close_lvl <= 1'b1;
    idle(3);
    st(32'h000A0080, M);
    close_lvl <= 1'b0;
    want_wired <= 1'b0;
    emerg_clear <= 1'b0;
    idle(SETTLE);
    st(32'h000A0020, 32'h000F1020);
    emerg_clear <= 1'b1;
    idle(SETTLE);
    st(32'h00090000, M);
    wr(ADDR_CONFIG, 32'h6B);
    estop_pressed <= 1'b1;
    idle(SETTLE);
    st(32'h00001000, M);
    check("relay", {31'h0, emstop_relay, emstop_lamp}, 33'h3);
    wr(ADDR_BUS_CMD, 32'h11);
    wr(ADDR_BUS_CMD, 32'h01);
    estop_pressed <= 1'b0;
    local_reset_button <= 1'b1;
    idle(SETTLE);
    st(32'h00081000, M);
    local_reset_button <= 1'b0;
    wr(ADDR_BUS_CMD, 32'h11);
    idle(3);
    st(32'h00090000, M);
    wr(ADDR_BUS_CMD, 32'h0);
    wr(ADDR_CONFIG, 32'h11);
    wr(ADDR_SAFETY, 32'h35A);
    want_wired <= 1'b1;
    idle(SETTLE);
    st(32'h000C0080, M);
    rnd_on <= 1'b0;
    idle(3);
    check("setpoint", {25'h0, position_setpoint},
          {25'h0, analogue_input_first});
    setpoint_lost <= 1'b1;
    idle(3);
    check("safety", {25'h0, position_setpoint}, 33'h05A);
    check("pending", 33'(notes.size()), 33'h0);
    stop_test();
  end
endmodule
